/* dv/csl_loader_props.sv */
// Checker for the loader command port and readout stream.
// Assumes one clock domain and CE_IN held high while checked.
`timescale 1ns/1ps
module csl_loader_props import csl_pkg::*; (
	// Clock, resets, straps
	input wire logic SYS_CLK_IN,
	input wire logic RESET_N_IN,
	input wire logic NV_BLANK_N_IN,
	input wire logic CE_IN,
	input wire logic VARIANT_WIDE_IN,
	// Command port
	input wire logic CMD_VALID_IN,
	input wire csl_cmd_t CMD_IN,
	input wire logic BUSY_OUT,
	input wire logic DONE_OUT,
	input wire logic ERR_OUT,
	input wire logic BOOTED_OUT,
	input wire logic [2:0] ACTIVE_IMG_OUT,
	input wire logic RD_VALID_OUT
);
	default clocking @(posedge SYS_CLK_IN); endclocking
	default disable iff (!RESET_N_IN);
	logic take;
	assign take = CE_IN && !BUSY_OUT && CMD_VALID_IN;
	////////////////////////////////////////////////////////////////////////
	err_pulse_a: assert property (ERR_OUT && !take |=> !ERR_OUT)
		else $error("error flag longer than one cycle");
	take_answer_a: assert property (take |-> ##[1:200] (DONE_OUT || ERR_OUT))
		else $error("command never answered");
	fac_guard_a: assert property (take && CMD_IN.img == IMG_FACTORY
		&& (CMD_IN.op == OP_SAVE || CMD_IN.op == OP_UPLOAD) |=> ERR_OUT) else $error("factory write not refused");
	wide_guard_a: assert property (VARIANT_WIDE_IN [*3] ##0 take && CMD_IN.img > SLOTS_WIDE |=> ERR_OUT)
		else $error("absent slot not refused");
	rd_burst_a: assert property ($rose(RD_VALID_OUT) |-> ##63 RD_VALID_OUT ##1 !RD_VALID_OUT)
		else $error("readout burst not 64 words");
	link_done_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN || !NV_BLANK_N_IN)
		$changed(ACTIVE_IMG_OUT) |-> DONE_OUT) else $error("boot link moved without completion");
	boot_busy_a: assert property (!BOOTED_OUT |-> BUSY_OUT)
		else $error("idle before boot load");
	done_idle_a: assert property (DONE_OUT && !take |=> !BUSY_OUT)
		else $error("busy after completion");
	cover property (take && CMD_IN.op == OP_ACTIVATE);
	cover property (take && CMD_IN.op == OP_UPLOAD);
	cover property ($rose(RD_VALID_OUT));
endmodule

/* dv/csl_loader_tb_top.sv */
// Self-checking bench for the configuration set loader.
// Assumes the loader package and a 200 MHz clock.
`timescale 1ns/1ps
module csl_loader_tb_top import csl_pkg::*;;
	logic clk, ce, rst_n, blank_n, wide, hwr, cvld, uvld, busy, done, err, booted, lvld, urdy, rvld;
	logic [AW-1:0] haddr, laddr;
	logic [DW-1:0] hdata, ldata, udata, rdata;
	logic [2:0] aimg;
	csl_cmd_t cmdw;
	logic [DW-1:0] ex [64], fa [64], s1 [64], up [64], q [$];
	int bad_count = 0, num_checks = 0, cyc = 0;
	csl_loader i_csl_loader (.SYS_CLK_IN(clk), .RESET_N_IN(rst_n), .NV_BLANK_N_IN(blank_n), .CE_IN(ce),
		.VARIANT_WIDE_IN(wide), .HOST_WR_IN(hwr), .HOST_ADDR_IN(haddr), .HOST_DATA_IN(hdata),
		.LIVE_ADDR_IN(laddr), .LIVE_DATA_OUT(ldata), .CMD_VALID_IN(cvld), .CMD_IN(cmdw), .BUSY_OUT(busy),
		.DONE_OUT(done), .ERR_OUT(err), .BOOTED_OUT(booted), .ACTIVE_IMG_OUT(aimg), .LINK_VALID_OUT(lvld),
		.UPL_VALID_IN(uvld), .UPL_DATA_IN(udata), .UPL_READY_OUT(urdy), .RD_VALID_OUT(rvld), .RD_DATA_OUT(rdata));
	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	// Ceiling well above the roughly 1100 cycles the sequence needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			complete_run();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task tick;
		@(posedge clk);
		#1;
	endtask
	task check(input logic [DW-1:0] s, input logic [DW-1:0] e);
		num_checks++;
		if (s !== e) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, s, e);
		end
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk_img;
		for (int a = 0; a < 64; a++) begin
			laddr = a[AW-1:0];
			tick;
			check(ldata, ex[a]);
		end
	endtask
	task chk_q(input logic [DW-1:0] e [64]);
		check(DW'(q.size()), 16'h0040);
		for (int i = 0; i < 64 && i < q.size(); i++)
			check(q[i], e[i]);
	endtask
	task do_reset;
		rst_n = 0;
		repeat (4) tick;
		rst_n = 1;
		blank_n = 1;
		for (int n = 0; n < 200 && busy !== 1'b0; n++)
			tick;
		check({15'h0000, busy}, 16'h0000);
		check({15'h0000, booted}, 16'h0001);
	endtask
	// Feeds upload words while ready, gathers readout words
	task automatic cmd(input csl_op_t op, input logic [2:0] img, input logic e);
		int n;
		int w;
		n = 0;
		w = 0;
		q.delete();
		cvld = 1;
		cmdw = '{op, img};
		tick;
		cvld = 0;
		while (done !== 1'b1 && err !== 1'b1 && n < 200) begin
			if (rvld === 1'b1)
				q.push_back(rdata);
			uvld = urdy === 1'b1 && w < 64;
			udata = up[w[5:0]];
			if (uvld)
				w++;
			tick;
			n++;
		end
		uvld = 0;
		check({14'h0000, done, err}, {14'h0000, ~e, e});
		tick;
	endtask
	////////////////////////////////////////////////////////////////////////
	task t_boot;
		// A frozen enable must swallow host writes
		ce = 0;
		hwr = 1;
		hdata = 16'hFFFF;
		repeat (2) tick;
		hwr = 0;
		ce = 1;
		ex = fa;
		chk_img;
		check({15'h0000, lvld}, 16'h0000);
	endtask
	task t_save;
		hwr = 1;
		hdata = 16'hA5A5;
		tick;
		haddr = 6'h3F;
		hdata = 16'h0F0F;
		tick;
		hwr = 0;
		ex[0] = 16'hA5A5;
		ex[63] = 16'h0F0F;
		chk_img;
		cmd(OP_SAVE, IMG_ONE, 0);
		s1 = ex;
		cmd(OP_READ, IMG_ONE, 0);
		chk_q(ex);
	endtask
	task t_refuse;
		cmd(OP_SAVE, IMG_FACTORY, 1);
		cmd(OP_UPLOAD, IMG_FACTORY, 1);
		cmd(OP_ACTIVATE, 3'h3, 1);
		cmd(OP_READ, 3'h4, 1);
		chk_img;
		check({15'h0000, urdy}, 16'h0000);
	endtask
	task t_upl;
		cmd(OP_UPLOAD, 3'h2, 0);
		cmd(OP_ACTIVATE, 3'h2, 0);
		ex = up;
		chk_img;
		check({13'h0000, aimg}, 16'h0002);
		check({15'h0000, lvld}, 16'h0001);
	endtask
	task t_reboot;
		hwr = 1;
		haddr = 6'h05;
		hdata = 16'h1234;
		tick;
		hwr = 0;
		do_reset;
		chk_img;
		cmd(OP_READ, IMG_ONE, 0);
		chk_q(s1);
	endtask
	task t_wide;
		wide = 1;
		repeat (3) tick;
		cmd(OP_SAVE, 3'h3, 1);
		cmd(OP_READ, 3'h2, 0);
		chk_q(up);
		wide = 0;
		repeat (3) tick;
	endtask
	task t_fac;
		cmd(OP_ACTIVATE, IMG_FACTORY, 0);
		ex = fa;
		chk_img;
		check({13'h0000, aimg}, 16'h0000);
		cmd(OP_READ, IMG_FACTORY, 0);
		chk_q(fa);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		{rst_n, blank_n, wide, hwr, cvld, uvld} = 6'h00;
		ce = 1;
		haddr = 6'h00;
		laddr = 6'h00;
		hdata = 16'h0000;
		udata = 16'h0000;
		cmdw = '0;
		for (int i = 0; i < 64; i++) begin
			fa[i] = FAC_SEED ^ DW'(i);
			up[i] = 16'hC300 ^ DW'(i);
		end
		do_reset;
		t_boot;
		t_save;
		t_refuse;
		t_upl;
		t_reboot;
		t_wide;
		t_fac;
		complete_run;
	end
endmodule
bind csl_loader csl_loader_props i_csl_loader_props (.SYS_CLK_IN(SYS_CLK_IN), .RESET_N_IN(RESET_N_IN),
	.NV_BLANK_N_IN(NV_BLANK_N_IN), .CE_IN(CE_IN), .VARIANT_WIDE_IN(VARIANT_WIDE_IN), .CMD_VALID_IN(CMD_VALID_IN),
	.CMD_IN(CMD_IN), .BUSY_OUT(BUSY_OUT), .DONE_OUT(DONE_OUT), .ERR_OUT(ERR_OUT), .BOOTED_OUT(BOOTED_OUT),
	.ACTIVE_IMG_OUT(ACTIVE_IMG_OUT), .RD_VALID_OUT(RD_VALID_OUT));

/* inc/csl_pkg.sv */
// Shared constants and types of the configuration set loader.
// Assumes a single 200 MHz clock domain and one image layout for all stores.
package csl_pkg;

	////////////////////////////////////////////////////////////////////////
	// Image geometry: parameter words followed by lookup-table words
	localparam int DW = 16;
	localparam int AW = 6;
	localparam int UAW = 8;
	localparam logic [AW-1:0] WORD_FIRST = 6'h00;
	localparam logic [AW-1:0] WORD_LAST = 6'h3F;
	localparam logic [AW-1:0] WORD_ONE = 6'h01;

	////////////////////////////////////////////////////////////////////////
	// Image selectors
	localparam logic [2:0] IMG_FACTORY = 3'h0;
	localparam logic [2:0] IMG_ONE = 3'h1;
	localparam logic [2:0] SLOTS_FULL = 3'h4;
	localparam logic [2:0] SLOTS_WIDE = 3'h2;
	localparam logic [3:0] NO_SLOTS = 4'h0;

	// Factory contents seed; arbitrary value
	localparam logic [DW-1:0] FAC_SEED = 16'h5A00;

	////////////////////////////////////////////////////////////////////////
	// Commands and states
	typedef enum logic [1:0] {
		OP_SAVE = 2'h0,
		OP_ACTIVATE = 2'h1,
		OP_READ = 2'h2,
		OP_UPLOAD = 2'h3
	} csl_op_t;

	typedef struct packed {
		csl_op_t op;
		logic [2:0] img;
	} csl_cmd_t;

	typedef enum logic [2:0] {
		J_BOOT = 3'h0,
		J_ACT = 3'h1,
		J_SAVE = 3'h2,
		J_READ = 3'h3,
		J_UPL = 3'h4
	} csl_job_t;

	typedef enum logic [2:0] {
		ST_BOOT = 3'b000,
		ST_IDLE = 3'b001,
		ST_COPY = 3'b011,
		ST_DONE = 3'b010,
		ST_UPL = 3'b110
	} csl_state_t;

endpackage

/* rtl/csl_loader.sv */
// Configuration set loader: working store, factory image, user slots.
// Assumes commands and host writes come from logic on SYS_CLK_IN.
//
// Summary of operation
// - Host parameter writes go straight into the volatile working store only while BUSY_OUT is low.
// - Working store is volatile; reset always reloads it completely.
// - Factory image is constant storage; no path can write it.
// - Four user slots (two when VARIANT_WIDE_IN is high) keep saved images, untouched by device reset.
// - Save copies the whole working store into the named user slot.
// - Activate accepts the factory image or any stored user slot.
// - Activate copies the image into the working store at once.
// - Activate records the image persistently as the boot image.
// - First power-up after delivery loads the factory image.
// - Later power-ups or resets load the last activated image.
// - With no activated image, boot loads the factory image.
// - An image holds every parameter word and the lookup table.
// - Shading coefficients are outside images and never touched here.
// - Host can read out any stored user slot or the factory image.
// - Uploads to the factory image are refused; user uploads overwrite.
`timescale 1ns/1ps
module csl_loader import csl_pkg::*; (
	// Clock, resets, enable
	input wire logic SYS_CLK_IN,
	input wire logic RESET_N_IN,
	input wire logic NV_BLANK_N_IN,
	input wire logic CE_IN,
	// Variant strap pin
	input wire logic VARIANT_WIDE_IN,
	// Host parameter writes
	input wire logic HOST_WR_IN,
	input wire logic [AW-1:0] HOST_ADDR_IN,
	input wire logic [DW-1:0] HOST_DATA_IN,
	// Live parameter read
	input wire logic [AW-1:0] LIVE_ADDR_IN,
	output logic [DW-1:0] LIVE_DATA_OUT,
	// Command port
	input wire logic CMD_VALID_IN,
	input wire csl_cmd_t CMD_IN,
	output logic BUSY_OUT,
	output logic DONE_OUT,
	output logic ERR_OUT,
	output logic BOOTED_OUT,
	output logic [2:0] ACTIVE_IMG_OUT,
	output logic LINK_VALID_OUT,
	// Upload stream
	input wire logic UPL_VALID_IN,
	input wire logic [DW-1:0] UPL_DATA_IN,
	output logic UPL_READY_OUT,
	// Readout stream
	output logic RD_VALID_OUT,
	output logic [DW-1:0] RD_DATA_OUT
);

	////////////////////////////////////////////////////////////////////////
	// Functions

	function automatic logic [1:0] slot_idx(input logic [2:0] img);
		logic [2:0] t;
		t = img - IMG_ONE;
		return t[1:0];
	endfunction

	function automatic logic slot_present(input logic [2:0] img, input logic wide);
		return (img >= IMG_ONE) && (img <= (wide ? SLOTS_WIDE : SLOTS_FULL));
	endfunction

	// Factory contents are a fixed function of the word address
	function automatic logic [DW-1:0] factory_word(input logic [AW-1:0] a);
		return FAC_SEED ^ {{(DW-AW){1'b0}}, a};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Declarations

	csl_state_t state_r, state_nxt;
	csl_job_t job_r, job_nxt;
	logic [2:0] src_r, src_nxt;
	logic [AW-1:0] cnt_r, cnt_nxt;
	logic iss_r, iss_nxt;
	logic pv_r, pv_nxt;
	logic [AW-1:0] pa_r, pa_nxt;
	logic [DW-1:0] fac_r, fac_nxt;
	logic rdv_r, rdv_nxt;
	logic [DW-1:0] rdd_r, rdd_nxt;
	logic done_r, done_nxt;
	logic err_r, err_nxt;
	logic booted_r, booted_nxt;
	// Persistent bookkeeping, cleared only at delivery
	logic [3:0] valid_r, valid_nxt;
	logic [2:0] active_r, active_nxt;
	logic link_r, link_nxt;

	logic wide;
	logic cmd_ok;
	logic w_we;
	logic [AW-1:0] w_waddr;
	logic [DW-1:0] w_wdata;
	logic [DW-1:0] w_qa;
	logic u_we;
	logic [UAW-1:0] u_waddr;
	logic [DW-1:0] u_wdata;
	logic [DW-1:0] u_qa;
	logic [DW-1:0] src_data;

	////////////////////////////////////////////////////////////////////////
	// Storage

	csl_sync u_sync (
		.clk(SYS_CLK_IN),
		.rst_n(RESET_N_IN),
		.ce(CE_IN),
		.d(VARIANT_WIDE_IN),
		.q(wide)
	);

	// Working store: no shading data lives here or anywhere in this block
	csl_mem #(.AW_P(AW), .DW_P(DW)) u_work (
		.clk(SYS_CLK_IN),
		.ce(CE_IN),
		.we(w_we),
		.waddr(w_waddr),
		.wdata(w_wdata),
		.ra_addr(cnt_r),
		.ra_data(w_qa),
		.rb_addr(LIVE_ADDR_IN),
		.rb_data(LIVE_DATA_OUT)
	);

	// User slots, indexed by slot then word
	csl_mem #(.AW_P(UAW), .DW_P(DW)) u_user (
		.clk(SYS_CLK_IN),
		.ce(CE_IN),
		.we(u_we),
		.waddr(u_waddr),
		.wdata(u_wdata),
		.ra_addr({slot_idx(src_r), cnt_r}),
		.ra_data(u_qa),
		.rb_addr({slot_idx(src_r), cnt_r}),
		.rb_data()
	);

	////////////////////////////////////////////////////////////////////////
	// Store write steering

	always_comb begin
		src_data = (src_r == IMG_FACTORY) ? fac_r : u_qa;
		// Host writes are dropped while a copy owns the store
		w_we = 1'b0;
		w_waddr = HOST_ADDR_IN;
		w_wdata = HOST_DATA_IN;
		if (state_r == ST_IDLE && HOST_WR_IN) begin
			w_we = 1'b1;
		end else if (state_r == ST_COPY && pv_r && (job_r == J_BOOT || job_r == J_ACT)) begin
			w_we = 1'b1;
			w_waddr = pa_r;
			w_wdata = src_data;
		end
		u_we = 1'b0;
		u_waddr = {slot_idx(src_r), pa_r};
		u_wdata = w_qa;
		if (state_r == ST_COPY && pv_r && job_r == J_SAVE) begin
			u_we = 1'b1;
		end else if (state_r == ST_UPL && UPL_VALID_IN) begin
			u_we = 1'b1;
			u_waddr = {slot_idx(src_r), cnt_r};
			u_wdata = UPL_DATA_IN;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Command check

	always_comb begin
		unique case (CMD_IN.op)
			OP_SAVE: cmd_ok = slot_present(CMD_IN.img, wide);
			OP_UPLOAD: cmd_ok = slot_present(CMD_IN.img, wide);
			OP_ACTIVATE, OP_READ: begin
				cmd_ok = (CMD_IN.img == IMG_FACTORY) ||
					(slot_present(CMD_IN.img, wide) && valid_r[slot_idx(CMD_IN.img)]);
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer

	always_comb begin
		state_nxt = state_r;
		job_nxt = job_r;
		src_nxt = src_r;
		cnt_nxt = cnt_r;
		iss_nxt = iss_r;
		pv_nxt = iss_r;
		pa_nxt = cnt_r;
		fac_nxt = factory_word(cnt_r);
		rdv_nxt = pv_r && job_r == J_READ;
		rdd_nxt = src_data;
		done_nxt = 1'b0;
		err_nxt = 1'b0;
		booted_nxt = booted_r;
		valid_nxt = valid_r;
		active_nxt = active_r;
		link_nxt = link_r;
		unique case (state_r)
			ST_BOOT: begin
				job_nxt = J_BOOT;
				src_nxt = link_r ? active_r : IMG_FACTORY;
				cnt_nxt = WORD_FIRST;
				iss_nxt = 1'b1;
				state_nxt = ST_COPY;
			end
			ST_IDLE: begin
				if (CMD_VALID_IN) begin
					if (!cmd_ok) begin
						err_nxt = 1'b1;
					end else begin
						src_nxt = CMD_IN.img;
						cnt_nxt = WORD_FIRST;
						unique case (CMD_IN.op)
							OP_SAVE: job_nxt = J_SAVE;
							OP_ACTIVATE: job_nxt = J_ACT;
							OP_READ: job_nxt = J_READ;
							OP_UPLOAD: job_nxt = J_UPL;
						endcase
						iss_nxt = CMD_IN.op != OP_UPLOAD;
						state_nxt = (CMD_IN.op == OP_UPLOAD) ? ST_UPL : ST_COPY;
					end
				end
			end
			ST_COPY: begin
				// Every word of the image is walked, table included
				if (iss_r) begin
					cnt_nxt = cnt_r + WORD_ONE;
					iss_nxt = cnt_r != WORD_LAST;
				end else if (!pv_r && !rdv_r) begin
					state_nxt = ST_DONE;
				end
			end
			ST_UPL: begin
				if (UPL_VALID_IN) begin
					cnt_nxt = cnt_r + WORD_ONE;
					if (cnt_r == WORD_LAST) begin
						state_nxt = ST_DONE;
					end
				end
			end
			ST_DONE: begin
				done_nxt = job_r != J_BOOT;
				booted_nxt = 1'b1;
				if (job_r == J_ACT) begin
					active_nxt = src_r;
					link_nxt = 1'b1;
				end
				if (job_r == J_SAVE || job_r == J_UPL) begin
					valid_nxt[slot_idx(src_r)] = 1'b1;
				end
				state_nxt = ST_IDLE;
			end
			default: state_nxt = ST_BOOT;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Registers

	// Device reset wipes sequencing and forces a fresh boot load
	always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			state_r <= ST_BOOT;
			job_r <= J_BOOT;
			src_r <= IMG_FACTORY;
			cnt_r <= WORD_FIRST;
			iss_r <= 1'b0;
			pv_r <= 1'b0;
			pa_r <= WORD_FIRST;
			fac_r <= FAC_SEED;
			rdv_r <= 1'b0;
			rdd_r <= FAC_SEED;
			done_r <= 1'b0;
			err_r <= 1'b0;
			booted_r <= 1'b0;
		end else if (CE_IN) begin
			state_r <= state_nxt;
			job_r <= job_nxt;
			src_r <= src_nxt;
			cnt_r <= cnt_nxt;
			iss_r <= iss_nxt;
			pv_r <= pv_nxt;
			pa_r <= pa_nxt;
			fac_r <= fac_nxt;
			rdv_r <= rdv_nxt;
			rdd_r <= rdd_nxt;
			done_r <= done_nxt;
			err_r <= err_nxt;
			booted_r <= booted_nxt;
		end
	end

	// Non-volatile bookkeeping survives device reset by design
	always_ff @(posedge SYS_CLK_IN or negedge NV_BLANK_N_IN) begin
		if (!NV_BLANK_N_IN) begin
			valid_r <= NO_SLOTS;
			active_r <= IMG_FACTORY;
			link_r <= 1'b0;
		end else if (CE_IN) begin
			valid_r <= valid_nxt;
			active_r <= active_nxt;
			link_r <= link_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign BUSY_OUT = state_r != ST_IDLE;
	assign DONE_OUT = done_r;
	assign ERR_OUT = err_r;
	assign BOOTED_OUT = booted_r;
	assign ACTIVE_IMG_OUT = active_r;
	assign LINK_VALID_OUT = link_r;
	assign UPL_READY_OUT = state_r == ST_UPL;
	assign RD_VALID_OUT = rdv_r;
	assign RD_DATA_OUT = rdd_r;

endmodule

/* rtl/csl_mem.sv */
// Storage array: one write port, two read ports with registered data.
// Assumes content is never reset; holders reload or track validity.
`timescale 1ns/1ps
module csl_mem #(
	parameter int AW_P = 6,
	parameter int DW_P = 16
) (
	input wire logic clk,
	input wire logic ce,
	input wire logic we,
	input wire logic [AW_P-1:0] waddr,
	input wire logic [DW_P-1:0] wdata,
	input wire logic [AW_P-1:0] ra_addr,
	output logic [DW_P-1:0] ra_data,
	input wire logic [AW_P-1:0] rb_addr,
	output logic [DW_P-1:0] rb_data
);
	logic [DW_P-1:0] mem [0:(1<<AW_P)-1];

	always_ff @(posedge clk) begin
		if (ce) begin
			if (we) begin
				mem[waddr] <= wdata;
			end
			ra_data <= mem[ra_addr];
			rb_data <= mem[rb_addr];
		end
	end
endmodule

/* rtl/csl_sync.sv */
// Two-flop synchroniser for one level from a pin.
// Assumes the destination is clocked by the loader clock.
`timescale 1ns/1ps
module csl_sync (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic d,
	output logic q
);
	logic meta_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= 1'b0;
			q <= 1'b0;
		end else if (ce) begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule
